// ==== verilog/bcb_branch_unit.sv ====
// Execution of the bit-set, bit-set-and-clear and carry conditional relative branches.
// Assumes bit space answers bit_rdata in the same cycle as bit_req.rd and that
// fetch presents the full instruction with instr_valid while the unit is not busy.
`timescale 1ns/1ps
module bcb_branch_unit #(
  parameter int unsigned MC_CLKS = bcb_pkg::MC_CLKS
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Instruction from fetch
  input  wire logic                 instr_valid,
  input  wire bcb_pkg::bcb_instr_t  instr,
  // Core state
  input  wire logic                 carry,
  input  wire logic                 bit_rdata,
  // Bit space access
  output bcb_pkg::bcb_bit_req_t     bit_req,
  // Program counter update and status
  output bcb_pkg::bcb_pc_upd_t      pc_upd,
  output logic                      busy,
  output logic                      reject
);

  typedef enum logic [1:0] {
    BCB_IDLE,
    BCB_FIRST,
    BCB_SECOND
  } bcb_state_t;

  bcb_state_t            state;
  bcb_state_t            next_state;
  logic [3:0]            mc_cnt;
  bcb_pkg::bcb_instr_t   cur;
  bcb_pkg::bcb_op_t      cur_op;
  logic                  cond;

  wire bcb_pkg::bcb_op_t  in_op    = bcb_pkg::bcb_decode(instr.opcode);
  wire                    accept   = (state == BCB_IDLE) && instr_valid
                                     && (in_op != bcb_pkg::BCB_NONE);
  wire                    unknown  = (state == BCB_IDLE) && instr_valid
                                     && (in_op == bcb_pkg::BCB_NONE);
  wire                    mc_end   = (mc_cnt == 4'(MC_CLKS - 1));
  wire                    sample   = (state == BCB_FIRST) && (mc_cnt == 4'h0);
  wire                    is_carry = (cur_op == bcb_pkg::BCB_CARRY);
  wire                    is_clr   = (cur_op == bcb_pkg::BCB_BIT_CLR);
  // Carry branch tests the flag, both bit branches test the addressed bit
  wire                    next_cond = is_carry ? carry : bit_rdata;
  wire                    finish   = (state == BCB_SECOND) && mc_end;
  wire                    clr_now  = (state == BCB_FIRST) && mc_end && is_clr;
  wire [1:0]              cur_len  = is_carry ? bcb_pkg::LEN_CARRY : bcb_pkg::LEN_BIT;
  // Carry branch carries its displacement in byte 2, bit branches in byte 3
  wire [7:0]              cur_disp = is_carry ? cur.byte2 : cur.byte3;
  wire [bcb_pkg::PC_W-1:0] next_target;

  bcb_target u_target (
    .pc     (cur.pc),
    .len    (cur_len),
    .disp   (cur_disp),
    .taken  (cond),
    .target (next_target)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      BCB_IDLE: begin
        if (accept) begin
          next_state = BCB_FIRST;
        end
      end
      BCB_FIRST: begin
        if (mc_end) begin
          next_state = BCB_SECOND;
        end
      end
      BCB_SECOND: begin
        if (mc_end) begin
          next_state = BCB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state  <= BCB_IDLE;
      mc_cnt <= 4'h0;
    end else begin
      state  <= next_state;
      mc_cnt <= (accept || mc_end) ? 4'h0 : 4'(mc_cnt + 4'h1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cur    <= '0;
      cur_op <= bcb_pkg::BCB_NONE;
      cond   <= 1'b0;
    end else begin
      if (accept) begin
        cur    <= instr;
        cur_op <= in_op;
      end
      if (sample) begin
        cond <= next_cond;
      end
    end
  end

  // Bit read is issued on the first cycle; bit-clear reads the port latch, not the pin
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_req <= '0;
    end else begin
      bit_req.rd         <= accept && (in_op != bcb_pkg::BCB_CARRY);
      bit_req.from_latch <= accept && (in_op == bcb_pkg::BCB_BIT_CLR);
      bit_req.wr         <= clr_now;
      bit_req.wdata      <= 1'b0;
      if (accept) begin
        bit_req.addr <= instr.byte2;
      end
    end
  end

  // Clear is written whatever the outcome: a zero bit stays zero, so it is harmless
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pc_upd <= '0;
      busy   <= 1'b0;
      reject <= 1'b0;
    end else begin
      pc_upd.load <= finish;
      if (finish) begin
        pc_upd.taken  <= cond;
        pc_upd.target <= next_target;
      end
      busy   <= accept || (busy && !finish);
      reject <= unknown;
    end
  end

  // Checking helpers
  logic [7:0] exec_cnt;
  logic       clr_seen;
  wire [bcb_pkg::PC_W-1:0] exp_seq = bcb_pkg::PC_W'(cur.pc + {14'h0000, cur_len});
  wire [bcb_pkg::PC_W-1:0] exp_rel = {{8{cur_disp[7]}}, cur_disp};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      exec_cnt <= 8'h00;
      clr_seen <= 1'b0;
    end else begin
      exec_cnt <= accept ? 8'h00 : (busy ? 8'(exec_cnt + 8'h01) : exec_cnt);
      clr_seen <= accept ? 1'b0 : (clr_seen || (bit_req.wr && !bit_req.wdata));
    end
  end

  AST_BIT_SET_NO_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
    bit_req.wr |-> is_clr)
    else $error("Bit written by a branch other than bit-clear");

  AST_BIT_SET_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && (cur_op == bcb_pkg::BCB_BIT_SET)
      |-> pc_upd.target == (pc_upd.taken ? 16'(exp_seq + exp_rel) : exp_seq))
    else $error("Bit-set branch target wrong");

  AST_BIT_SET_CYCLES: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && (cur_op == bcb_pkg::BCB_BIT_SET)
      |-> exec_cnt == 8'(bcb_pkg::EXEC_MC * MC_CLKS) && cur.opcode == 8'h20)
    else $error("Bit-set branch length or opcode wrong");

  AST_CLR_ALWAYS: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && is_clr |-> clr_seen && !$past(busy, 1) == 1'b0)
    else $error("Bit-clear branch finished without clearing the bit");

  AST_CLR_FROM_LATCH: assert property (@(posedge clock) disable iff (!rst_n)
    bit_req.rd && is_clr |-> bit_req.from_latch && bit_req.addr == cur.byte2)
    else $error("Bit-clear branch did not read the output latch");

  AST_CLR_CYCLES: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(busy) && is_clr |-> !pc_upd.load [*2] ##0 busy)
    else $error("Bit-clear branch finished too early");

  AST_CLR_TARGET: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && is_clr
      |-> pc_upd.target == (pc_upd.taken ? 16'(exp_seq + exp_rel) : exp_seq))
    else $error("Bit-clear branch target wrong");

  AST_CARRY_TAKEN: assert property (@(posedge clock) disable iff (!rst_n)
    sample && is_carry ##1 (busy [*1] ##0 1'b1) |-> cond == $past(carry, 1))
    else $error("Carry branch did not follow the carry flag");

  AST_CARRY_CYCLES: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && is_carry |-> exec_cnt == 8'(bcb_pkg::EXEC_MC * MC_CLKS) && !bit_req.rd)
    else $error("Carry branch length wrong");

  AST_SIGNED_DISP: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && pc_upd.taken && cur_disp[7] |-> 16'(exp_seq - pc_upd.target) <= 16'h0080)
    else $error("Negative displacement not sign-extended");

  AST_WRAP: assert property (@(posedge clock) disable iff (!rst_n)
    pc_upd.load && !pc_upd.taken |-> pc_upd.target == 16'(cur.pc + {14'h0000, cur_len}))
    else $error("Sequential address did not wrap");

  COV_BIT_SET_TAKEN: cover property (@(posedge clock)
    pc_upd.load && pc_upd.taken && cur_op == bcb_pkg::BCB_BIT_SET);
  COV_CLR_NOT_TAKEN: cover property (@(posedge clock)
    pc_upd.load && !pc_upd.taken && is_clr);
  COV_CARRY_TAKEN: cover property (@(posedge clock)
    pc_upd.load && pc_upd.taken && is_carry);
  // Busy is already low in the load cycle, so back to back shows as an accept there
  COV_BACK_TO_BACK: cover property (@(posedge clock)
    pc_upd.load && accept);

endmodule

// ==== verilog/bcb_pkg.sv ====
// Constants, types and helper functions of the bit and carry conditional branch unit.
// Assumes one core clock; fetch hands over all operand bytes together with the opcode.
package bcb_pkg;

  localparam int         PC_W        = 16;
  localparam int         DISP_W      = 8;
  localparam logic [7:0] OP_BIT_SET  = 8'h20;
  localparam logic [7:0] OP_BIT_CLR  = 8'h10;
  localparam logic [7:0] OP_CARRY    = 8'h40;
  localparam logic [1:0] LEN_BIT     = 2'h3;
  localparam logic [1:0] LEN_CARRY   = 2'h2;
  // Execution length in machine cycles and clocks per machine cycle
  localparam int         EXEC_MC     = 2;
  localparam int         MC_CLKS     = 1;

  typedef enum logic [1:0] {
    BCB_NONE,
    BCB_BIT_SET,
    BCB_BIT_CLR,
    BCB_CARRY
  } bcb_op_t;

  typedef struct packed {
    logic [7:0]      opcode;
    logic [7:0]      byte2;
    logic [7:0]      byte3;
    logic [PC_W-1:0] pc;
  } bcb_instr_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       from_latch;
    logic [7:0] addr;
    logic       wdata;
  } bcb_bit_req_t;

  typedef struct packed {
    logic            load;
    logic            taken;
    logic [PC_W-1:0] target;
  } bcb_pc_upd_t;

  function automatic bcb_op_t bcb_decode(input logic [7:0] opcode);
    bcb_op_t op;
    op = BCB_NONE;
    if (opcode == OP_BIT_SET) begin
      op = BCB_BIT_SET;
    end else if (opcode == OP_BIT_CLR) begin
      op = BCB_BIT_CLR;
    end else if (opcode == OP_CARRY) begin
      op = BCB_CARRY;
    end
    return op;
  endfunction

  function automatic logic [PC_W-1:0] bcb_sext(input logic [DISP_W-1:0] disp);
    return {{(PC_W-DISP_W){disp[DISP_W-1]}}, disp};
  endfunction

endpackage

// ==== verilog/bcb_target.sv ====
// Branch target adder: sequential address, plus displacement when taken.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module bcb_target (
  // Instruction
  input  wire logic [bcb_pkg::PC_W-1:0]   pc,
  input  wire logic [1:0]                 len,
  input  wire logic [bcb_pkg::DISP_W-1:0] disp,
  // Outcome
  input  wire logic                       taken,
  output logic      [bcb_pkg::PC_W-1:0]   target
);

  logic [bcb_pkg::PC_W-1:0] seq_pc;
  logic [bcb_pkg::PC_W-1:0] rel_pc;

  // Sums are cut to pc width on purpose: wrap-around is silent
  assign seq_pc = bcb_pkg::PC_W'(pc + {{(bcb_pkg::PC_W-2){1'b0}}, len});
  assign rel_pc = bcb_pkg::PC_W'(seq_pc + bcb_pkg::bcb_sext(disp));
  assign target = taken ? rel_pc : seq_pc;

endmodule

// ==== verification/tb_bcb_branch_unit.sv ====
// Self-checking bench for the conditional relative branch unit.
// Assumes MC_CLKS of 1; bit value and carry are held from issue until the next issue.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_bcb_branch_unit;
  typedef struct packed {
    logic        rej;
    logic        clr;
    logic        bitop;
    logic        taken;
    logic [15:0] target;
    logic [7:0]  addr;
  } bcb_note_t;
  logic                  clock = 0;
  logic                  rst_n = 0;
  logic                  instr_valid = 0;
  bcb_pkg::bcb_instr_t   instr = '0;
  logic                  carry = 0;
  logic                  bit_rdata = 0;
  bcb_pkg::bcb_bit_req_t bit_req;
  bcb_pkg::bcb_pc_upd_t  pc_upd;
  logic                  busy;
  logic                  reject;
  bcb_note_t             q[$];
  bcb_note_t             n;
  logic                  rd_seen = 0;
  logic                  wr_seen = 0;
  int                    bad_count = 0;
  int                    samples_checked = 0;
  integer                seed = 7005;
  always #50 clock = ~clock;
  bcb_branch_unit #(.MC_CLKS(1)) u_bcb_branch_unit (
    .clock(clock), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr), .carry(carry),
    .bit_rdata(bit_rdata), .bit_req(bit_req), .pc_upd(pc_upd), .busy(busy), .reject(reject));
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Without hold, ends at the accept edge plus one, so a following call lands in the load cycle
  task automatic issue(input logic [7:0] op, b2, b3, input logic [15:0] pc,
                       input logic bv, cy, input bit hold);
    bcb_note_t   e;
    logic [7:0]  d;
    logic [15:0] len;
    e.rej    = !(op == bcb_pkg::OP_BIT_SET || op == bcb_pkg::OP_BIT_CLR ||
                 op == bcb_pkg::OP_CARRY);
    e.clr    = (op == bcb_pkg::OP_BIT_CLR);
    e.bitop  = (op != bcb_pkg::OP_CARRY);
    e.taken  = e.bitop ? bv : cy;
    d        = e.bitop ? b3 : b2;
    len      = e.bitop ? 16'h0003 : 16'h0002;
    e.target = pc + len + (e.taken ? {{8{d[7]}}, d} : 16'h0000);
    e.addr   = b2;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr       <= {op, b2, b3, pc};
    bit_rdata   <= bv;
    carry       <= cy;
    q.push_back(e);
    @(posedge clock);
    if (hold) begin
      // A second request held through both busy cycles must leave no trace
      instr <= {bcb_pkg::OP_CARRY, 8'h11, 8'h22, 16'h5555};
      repeat (2) @(posedge clock);
    end
    instr_valid <= 1'b0;
    if (!hold) @(posedge clock);
  endtask
  always @(negedge clock) begin
    if (rst_n && (pc_upd.load || reject || bit_req.rd || bit_req.wr)) begin
      if (q.size() == 0) begin
        `CHK("spare output", 1'b0, 1'b1)
      end else begin
        n = q[0];
        if (bit_req.rd) begin
          rd_seen = 1'b1;
          `CHK("busy in exec", 1'b1, busy)
          `CHK("rd on bit op", 1'b1, n.bitop)
          `CHK("from_latch", n.clr, bit_req.from_latch)
          `CHK("bit addr", n.addr, bit_req.addr)
        end
        if (bit_req.wr) begin
          wr_seen = 1'b1;
          `CHK("wr on clear op", 1'b1, n.clr)
          `CHK("wdata", 1'b0, bit_req.wdata)
        end
        if (reject || pc_upd.load) begin
          `CHK("reject", n.rej, reject)
          `CHK("busy when done", 1'b0, busy)
          if (pc_upd.load) begin
            `CHK("bit read seen", n.bitop, rd_seen)
            `CHK("clear seen", n.clr, wr_seen)
            `CHK("taken", n.taken, pc_upd.taken)
            `CHK("target", n.target, pc_upd.target)
          end
          rd_seen = 1'b0;
          wr_seen = 1'b0;
          void'(q.pop_front());
        end
      end
    end
  end
  initial begin
    repeat (3000) @(posedge clock);
    bad_count++;
    give_verdict();
  end
  initial begin
    logic [7:0] op;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    `CHK("busy after reset", 1'b0, busy)
    `CHK("load after reset", 1'b0, pc_upd.load)
    $display("test reset done");
    // Both outcomes of each branch, displacement extremes and pc wrap
    issue(bcb_pkg::OP_BIT_SET, 8'h92, 8'h7f, 16'h1000, 1, 0, 0);
    issue(bcb_pkg::OP_BIT_SET, 8'h93, 8'h80, 16'h1000, 0, 1, 0);
    issue(bcb_pkg::OP_BIT_CLR, 8'he2, 8'h80, 16'h0010, 1, 0, 0);
    issue(bcb_pkg::OP_BIT_CLR, 8'h90, 8'h05, 16'h2000, 0, 1, 0);
    issue(bcb_pkg::OP_CARRY, 8'h80, 8'h33, 16'h0040, 0, 1, 0);
    issue(bcb_pkg::OP_CARRY, 8'hfe, 8'h00, 16'h0100, 1, 0, 0);
    issue(bcb_pkg::OP_CARRY, 8'h7f, 8'h00, 16'hfffe, 0, 1, 0);
    issue(bcb_pkg::OP_BIT_SET, 8'h01, 8'h02, 16'hfffd, 1, 0, 0);
    repeat (3) @(posedge clock);
    $display("test directed done");
    for (int i = 0; i < 30; i++) begin
      case ($unsigned($random(seed)) % 3)
        0: op = bcb_pkg::OP_BIT_SET;
        1: op = bcb_pkg::OP_BIT_CLR;
        default: op = bcb_pkg::OP_CARRY;
      endcase
      issue(op, 8'($random(seed)), 8'($random(seed)), 16'($random(seed)),
            1'($random(seed)), 1'($random(seed)), 0);
    end
    repeat (3) @(posedge clock);
    $display("test random done");
    issue(bcb_pkg::OP_BIT_CLR, 8'h20, 8'hf0, 16'h3000, 1, 0, 1);
    issue(bcb_pkg::OP_BIT_SET, 8'h21, 8'h10, 16'h3100, 0, 1, 1);
    repeat (3) @(posedge clock);
    $display("test busy refusal done");
    issue(8'h30, 8'h00, 8'h00, 16'h0000, 1, 1, 0);
    issue(8'h41, 8'h00, 8'h00, 16'h0000, 1, 1, 0);
    issue(8'h11, 8'h00, 8'h00, 16'h0000, 1, 1, 0);
    issue(bcb_pkg::OP_CARRY, 8'h04, 8'h00, 16'h0200, 0, 1, 0);
    repeat (4) @(posedge clock);
    $display("test reject done");
    `CHK("pending results", 0, q.size())
    give_verdict();
  end
endmodule
